// >>> logic/wd_window_pkg.sv
// constants and types for the communication watchdog register window
// assumes a 16-bit register request port fed by the protocol engine
package wd_window_pkg;

	// register addresses of the special window
	localparam logic [15:0] REG_COMMAND     = 16'hfa00;
	localparam logic [15:0] REG_TIMEOUT     = 16'hfa01;
	localparam logic [15:0] REG_STATE       = 16'hfa02;
	localparam logic [15:0] REG_OPTIONS     = 16'hfa03;
	localparam logic [15:0] REG_TCP_GUARD   = 16'hfa04;
	localparam logic [15:0] REG_FLASH_1     = 16'hfa0a;
	localparam logic [15:0] REG_FLASH_2     = 16'hfa0b;
	localparam logic [15:0] REG_FLASH_3     = 16'hfa0c;
	localparam logic [15:0] REG_RUN_STATE   = 16'hfa0d;
	localparam logic [15:0] REG_ORDER_0     = 16'hfa10;
	localparam logic [15:0] REG_ORDER_1     = 16'hfa11;
	localparam logic [15:0] REG_ORDER_2     = 16'hfa12;
	localparam logic [15:0] REG_ORDER_3     = 16'hfa13;
	localparam logic [15:0] REG_FW_REV      = 16'hfa14;
	localparam logic [15:0] REG_HW_REV      = 16'hfa15;
	localparam logic [15:0] REG_BOOT_REV    = 16'hfa16;
	localparam logic [15:0] REG_IMAGE_REV   = 16'hfa17;
	localparam logic [15:0] REG_HWADDR_0    = 16'hfa20;
	localparam logic [15:0] REG_HWADDR_1    = 16'hfa21;
	localparam logic [15:0] REG_HWADDR_2    = 16'hfa22;
	localparam logic [15:0] REG_IN_TOTAL    = 16'hfa40;
	localparam logic [15:0] REG_IN_ANALOG   = 16'hfa41;
	localparam logic [15:0] REG_IN_DIGITAL  = 16'hfa42;
	localparam logic [15:0] REG_OUT_TOTAL   = 16'hfa43;
	localparam logic [15:0] REG_OUT_ANALOG  = 16'hfa44;
	localparam logic [15:0] REG_OUT_DIGITAL = 16'hfa45;
	localparam logic [15:0] REG_PATTERN_A   = 16'hfaa0;
	localparam logic [15:0] REG_PATTERN_B   = 16'hfaa1;
	localparam logic [15:0] REG_PATTERN_C   = 16'hfaa2;
	localparam logic [15:0] REG_HEARTBEAT   = 16'hfafa;

	// command words
	localparam logic [15:0] CMD_START = 16'h5555;
	localparam logic [15:0] CMD_STOP  = 16'h55aa;
	localparam logic [15:0] CMD_RESET = 16'haaaa;

	// status words
	localparam logic [15:0] STAT_UNCONFIGURED = 16'hffff;
	localparam logic [15:0] STAT_STOPPED      = 16'h0000;
	localparam logic [15:0] STAT_RUNNING      = 16'h0001;
	localparam logic [15:0] STAT_EXPIRED      = 16'h0002;

	// exception codes, zero means none
	localparam logic [7:0] EXC_NONE             = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDRESS  = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE    = 8'h03;

	// option bits and reset values
	localparam int          OPT_EXPLICIT_BIT   = 0;
	localparam int          OPT_STATUS_TRG_BIT = 1;
	localparam int          OPT_CLOSE_TCP_BIT  = 2;
	localparam int          OPT_SIMPLE_BIT     = 7;
	localparam logic [15:0] OPTIONS_RESET      = 16'h0004;
	localparam logic [15:0] TIMEOUT_RESET      = 16'h0000;
	localparam logic [15:0] TCP_GUARD_RESET    = 16'h0000;
	localparam logic [15:0] HEARTBEAT_RESET    = 16'h0000;

	// fixed words
	localparam logic [15:0] IMAGE_SIZE_WORDS   = 16'h7d00;
	localparam logic [15:0] IMAGE_SIZE_BITS    = 16'h8000;
	localparam logic [15:0] PATTERN_A          = 16'h1234;
	localparam logic [15:0] PATTERN_B          = 16'haaaa;
	localparam logic [15:0] PATTERN_C          = 16'h5555;
	localparam logic [15:0] RUN_WORD_STOP      = 16'h0001;
	localparam logic [15:0] RUN_WORD_RUN       = 16'h0002;

	// millisecond tick
	localparam int CLK_PERIOD_NS  = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		WD_STOPPED = 3'b001,
		WD_RUNNING = 3'b010,
		WD_EXPIRED = 3'b100
	} wd_state_type;

endpackage

// >>> logic/wd_timer_if.sv
// link between the register window and its timing helpers
// assumes all parties run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface wd_timer_if;
	logic        tick;
	logic        restart;
	logic [15:0] reload;
	logic        running;
	logic        expire;

	modport ctl (input tick, input expire,
		output restart, output reload, output running);
	modport pre (output tick);
	modport cnt (input tick, input restart, input reload,
		input running, output expire);
endinterface
`default_nettype wire

// >>> logic/ms_prescaler.sv
// divides the system clock down to a one-cycle millisecond tick
// assumes a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ms_prescaler #(
	parameter int CYCLES = wd_window_pkg::TICK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	wd_timer_if.pre  timer
);
	localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	typedef struct packed {
		logic [W-1:0] count;
		logic         tick;
	} pre_type;

	pre_type r_q;
	pre_type r_d;

	always_comb begin
		r_d = r_q;
		r_d.tick = (r_q.count == LAST);
		r_d.count = (r_q.count == LAST) ? '0 : r_q.count + W'(1);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign timer.tick = r_q.tick;
endmodule
`default_nettype wire

// >>> logic/wd_countdown.sv
// millisecond countdown of the watchdog interval
// assumes restart and running come from the register window
`timescale 1ns/1ps
`default_nettype none
module wd_countdown (
	input wire logic i_clk,
	input wire logic i_srst,
	wd_timer_if.cnt  timer
);
	typedef struct packed {
		logic [15:0] count;
		logic        expire;
	} cnt_type;

	cnt_type r_q;
	cnt_type r_d;

	always_comb begin
		r_d = r_q;
		r_d.expire = 1'b0;
		if (timer.restart) begin
			r_d.count = timer.reload;
		end else if (timer.running && timer.tick && r_q.count != 16'h0000) begin
			r_d.count = r_q.count - 16'h0001;
			r_d.expire = (r_q.count == 16'h0001);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign timer.expire = r_q.expire;
endmodule
`default_nettype wire

// >>> logic/modbus_comm_watchdog_regs.sv
// communication watchdog with its special register window
// assumes the protocol engine splits multi-word requests into single words
`timescale 1ns/1ps
`default_nettype none
module modbus_comm_watchdog_regs #(
	parameter int          TICK_CYCLES   = wd_window_pkg::TICK_CYCLES,
	// identity words, values arbitrary
	parameter logic [63:0] ORDER_CODE    = 64'h0000_0000_0000_0001,
	parameter logic [15:0] FW_REVISION   = 16'h0001,
	parameter logic [15:0] HW_REVISION   = 16'h0001,
	parameter logic [15:0] BOOT_REVISION = 16'h0001,
	parameter logic [15:0] IMAGE_REV     = 16'h0001
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SRST,
	// register requests from the protocol engine
	input  wire logic        I_REQ_VALID,
	input  wire logic        I_REQ_WRITE,
	input  wire logic [15:0] I_REQ_ADDR,
	input  wire logic [15:0] I_REQ_WDATA,
	input  wire logic        I_QUERY_SEEN,
	// answers
	output logic             O_RSP_VALID,
	output logic      [15:0] O_RSP_DATA,
	output logic       [7:0] O_RSP_EXCEPTION,
	// runtime inputs
	input  wire logic [47:0] I_IO_INDICATOR_CODE,
	input  wire logic        I_CONTROLLER_RUNNING,
	input  wire logic [47:0] I_HW_ADDRESS,
	// watchdog outputs
	output logic             O_EXPIRE_EVENT,
	output logic             O_CLOSE_TCP,
	output logic      [15:0] O_WD_STATUS,
	output logic      [15:0] O_TCP_GUARD
);

	typedef struct packed {
		wd_window_pkg::wd_state_type state;
		logic [15:0]                 timeout;
		logic [15:0]                 options;
		logic [15:0]                 tcp_guard;
		logic [15:0]                 heartbeat;
		logic [15:0]                 status;
		logic                        restart;
		logic                        rsp_valid;
		logic [15:0]                 rsp_data;
		logic [7:0]                  rsp_exc;
		logic                        expire_event;
		logic                        close_tcp;
	} regs_type;

	regs_type r_q;
	regs_type r_d;

	wd_timer_if timer ();

	ms_prescaler #(
		.CYCLES (TICK_CYCLES)
	) u_prescaler (
		.i_clk  (I_CLK),
		.i_srst (I_SRST),
		.timer  (timer.pre)
	);

	wd_countdown u_countdown (
		.i_clk  (I_CLK),
		.i_srst (I_SRST),
		.timer  (timer.cnt)
	);

	// status word from state and timeout
	function automatic logic [15:0] status_word(
		input wd_window_pkg::wd_state_type st,
		input logic [15:0]                 tmo
	);
		logic [15:0] w;
		w = wd_window_pkg::STAT_STOPPED;
		if (tmo == 16'h0000) begin
			w = wd_window_pkg::STAT_UNCONFIGURED;
		end else begin
			case (st)
				wd_window_pkg::WD_RUNNING: w = wd_window_pkg::STAT_RUNNING;
				wd_window_pkg::WD_EXPIRED: w = wd_window_pkg::STAT_EXPIRED;
				default:                   w = wd_window_pkg::STAT_STOPPED;
			endcase
		end
		return w;
	endfunction

	logic unconf;
	logic simple;
	logic explicit_only;
	logic trig;
	logic read_only;
	logic [7:0] exc;
	logic [15:0] rdata;

	always_comb begin
		r_d = r_q;
		r_d.rsp_valid = 1'b0;
		r_d.rsp_data = 16'h0000;
		r_d.rsp_exc = wd_window_pkg::EXC_NONE;
		r_d.restart = 1'b0;
		r_d.expire_event = 1'b0;
		r_d.close_tcp = 1'b0;
		unconf = (r_q.timeout == 16'h0000);
		simple = r_q.options[wd_window_pkg::OPT_SIMPLE_BIT];
		explicit_only = r_q.options[wd_window_pkg::OPT_EXPLICIT_BIT];
		trig = 1'b0;
		read_only = 1'b1;
		exc = wd_window_pkg::EXC_NONE;
		rdata = 16'h0000;

		if (timer.tick) begin
			r_d.heartbeat = r_q.heartbeat + 16'h0001;
		end

		// requests elsewhere in the map count unless explicit-only
		if (I_QUERY_SEEN && !explicit_only) begin
			trig = 1'b1;
		end

		if (I_REQ_VALID) begin
			// window accesses other than the status read are ordinary queries
			if (!explicit_only && I_REQ_ADDR != wd_window_pkg::REG_STATE) begin
				trig = 1'b1;
			end

			if (I_REQ_ADDR == wd_window_pkg::REG_COMMAND) begin
				read_only = 1'b0;
				if (I_REQ_WRITE) begin
					if (I_REQ_WDATA == wd_window_pkg::CMD_START) begin
						if (unconf || r_q.state == wd_window_pkg::WD_EXPIRED) begin
							exc = wd_window_pkg::EXC_ILLEGAL_VALUE;
						end else if (r_q.state == wd_window_pkg::WD_RUNNING) begin
							trig = 1'b1;
						end else begin
							r_d.state = wd_window_pkg::WD_RUNNING;
							r_d.restart = 1'b1;
						end
					end else if (I_REQ_WDATA == wd_window_pkg::CMD_STOP) begin
						if (unconf || simple) begin
							exc = wd_window_pkg::EXC_ILLEGAL_VALUE;
						end else begin
							r_d.state = wd_window_pkg::WD_STOPPED;
						end
					end else if (I_REQ_WDATA == wd_window_pkg::CMD_RESET) begin
						if (r_q.state != wd_window_pkg::WD_EXPIRED || simple) begin
							exc = wd_window_pkg::EXC_ILLEGAL_VALUE;
						end else begin
							r_d.state = wd_window_pkg::WD_STOPPED;
						end
					end else begin
						exc = wd_window_pkg::EXC_ILLEGAL_VALUE;
					end
				end
			end else if (I_REQ_ADDR == wd_window_pkg::REG_TIMEOUT) begin
				read_only = 1'b0;
				rdata = r_q.timeout;
				if (I_REQ_WRITE) begin
					if (r_q.state != wd_window_pkg::WD_STOPPED) begin
						exc = wd_window_pkg::EXC_ILLEGAL_FUNCTION;
					end else begin
						r_d.timeout = I_REQ_WDATA;
						// a zero write stays inactive and unconfigured
						if (simple && I_REQ_WDATA != 16'h0000) begin
							r_d.state = wd_window_pkg::WD_RUNNING;
							r_d.restart = 1'b1;
						end else begin
							r_d.state = wd_window_pkg::WD_STOPPED;
						end
					end
				end
			end else if (I_REQ_ADDR == wd_window_pkg::REG_STATE) begin
				rdata = r_q.status;
				if (!I_REQ_WRITE &&
					r_q.options[wd_window_pkg::OPT_STATUS_TRG_BIT]) begin
					trig = 1'b1;
				end
			end else if (I_REQ_ADDR == wd_window_pkg::REG_OPTIONS) begin
				read_only = 1'b0;
				rdata = r_q.options;
				if (I_REQ_WRITE) begin
					if (!simple && r_q.state != wd_window_pkg::WD_STOPPED) begin
						exc = wd_window_pkg::EXC_ILLEGAL_FUNCTION;
					end else begin
						r_d.options = I_REQ_WDATA;
						// leaving simple mode is the only way to stop it
						if (simple && !I_REQ_WDATA[wd_window_pkg::OPT_SIMPLE_BIT]) begin
							r_d.state = wd_window_pkg::WD_STOPPED;
						end
					end
				end
			end else if (I_REQ_ADDR == wd_window_pkg::REG_TCP_GUARD) begin
				read_only = 1'b0;
				rdata = r_q.tcp_guard;
				if (I_REQ_WRITE) begin
					r_d.tcp_guard = I_REQ_WDATA;
				end
			end else if (I_REQ_ADDR == wd_window_pkg::REG_FLASH_1) begin
				rdata = I_IO_INDICATOR_CODE[47:32];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_FLASH_2) begin
				rdata = I_IO_INDICATOR_CODE[31:16];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_FLASH_3) begin
				rdata = I_IO_INDICATOR_CODE[15:0];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_RUN_STATE) begin
				rdata = I_CONTROLLER_RUNNING ? wd_window_pkg::RUN_WORD_RUN
					: wd_window_pkg::RUN_WORD_STOP;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_ORDER_0) begin
				rdata = ORDER_CODE[63:48];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_ORDER_1) begin
				rdata = ORDER_CODE[47:32];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_ORDER_2) begin
				rdata = ORDER_CODE[31:16];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_ORDER_3) begin
				rdata = ORDER_CODE[15:0];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_FW_REV) begin
				rdata = FW_REVISION;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_HW_REV) begin
				rdata = HW_REVISION;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_BOOT_REV) begin
				rdata = BOOT_REVISION;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_IMAGE_REV) begin
				rdata = IMAGE_REV;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_HWADDR_0) begin
				rdata = I_HW_ADDRESS[47:32];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_HWADDR_1) begin
				rdata = I_HW_ADDRESS[31:16];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_HWADDR_2) begin
				rdata = I_HW_ADDRESS[15:0];
			end else if (I_REQ_ADDR == wd_window_pkg::REG_IN_TOTAL ||
				I_REQ_ADDR == wd_window_pkg::REG_IN_ANALOG ||
				I_REQ_ADDR == wd_window_pkg::REG_OUT_TOTAL ||
				I_REQ_ADDR == wd_window_pkg::REG_OUT_ANALOG) begin
				rdata = wd_window_pkg::IMAGE_SIZE_WORDS;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_IN_DIGITAL ||
				I_REQ_ADDR == wd_window_pkg::REG_OUT_DIGITAL) begin
				rdata = wd_window_pkg::IMAGE_SIZE_BITS;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_PATTERN_A) begin
				rdata = wd_window_pkg::PATTERN_A;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_PATTERN_B) begin
				rdata = wd_window_pkg::PATTERN_B;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_PATTERN_C) begin
				rdata = wd_window_pkg::PATTERN_C;
			end else if (I_REQ_ADDR == wd_window_pkg::REG_HEARTBEAT) begin
				rdata = r_q.heartbeat;
			end else begin
				exc = wd_window_pkg::EXC_ILLEGAL_ADDRESS;
			end

			// writes to read-only words change nothing
			if (I_REQ_WRITE && read_only) begin
				exc = wd_window_pkg::EXC_ILLEGAL_ADDRESS;
			end
			// refused requests are never triggers
			if (exc != wd_window_pkg::EXC_NONE) begin
				trig = 1'b0;
				rdata = 16'h0000;
			end
			// the command register reads back as zero
			if (I_REQ_WRITE || I_REQ_ADDR == wd_window_pkg::REG_COMMAND) begin
				rdata = 16'h0000;
			end
			r_d.rsp_valid = 1'b1;
			r_d.rsp_data = rdata;
			r_d.rsp_exc = exc;
		end

		// a trigger reloads the interval; simple mode also revives expiry
		if (trig) begin
			if (r_d.state == wd_window_pkg::WD_RUNNING) begin
				r_d.restart = 1'b1;
			end else if (r_d.state == wd_window_pkg::WD_EXPIRED && simple &&
				!unconf) begin
				r_d.state = wd_window_pkg::WD_RUNNING;
				r_d.restart = 1'b1;
			end
		end

		// a trigger in the expiry cycle wins and keeps the watchdog alive
		if (timer.expire && r_q.state == wd_window_pkg::WD_RUNNING &&
			r_d.state == wd_window_pkg::WD_RUNNING && !r_d.restart) begin
			r_d.state = wd_window_pkg::WD_EXPIRED;
			r_d.expire_event = 1'b1;
			r_d.close_tcp = r_q.options[wd_window_pkg::OPT_CLOSE_TCP_BIT];
		end

		r_d.status = status_word(r_d.state, r_d.timeout);
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			r_q.state <= wd_window_pkg::WD_STOPPED;
			r_q.timeout <= wd_window_pkg::TIMEOUT_RESET;
			r_q.options <= wd_window_pkg::OPTIONS_RESET;
			r_q.tcp_guard <= wd_window_pkg::TCP_GUARD_RESET;
			r_q.heartbeat <= wd_window_pkg::HEARTBEAT_RESET;
			r_q.status <= wd_window_pkg::STAT_UNCONFIGURED;
			r_q.restart <= 1'b0;
			r_q.rsp_valid <= 1'b0;
			r_q.rsp_data <= 16'h0000;
			r_q.rsp_exc <= wd_window_pkg::EXC_NONE;
			r_q.expire_event <= 1'b0;
			r_q.close_tcp <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// timer hand-off uses registered values only
	assign timer.restart = r_q.restart;
	assign timer.reload = r_q.timeout;
	assign timer.running = (r_q.state == wd_window_pkg::WD_RUNNING);

	assign O_RSP_VALID = r_q.rsp_valid;
	assign O_RSP_DATA = r_q.rsp_data;
	assign O_RSP_EXCEPTION = r_q.rsp_exc;
	assign O_EXPIRE_EVENT = r_q.expire_event;
	assign O_CLOSE_TCP = r_q.close_tcp;
	assign O_WD_STATUS = r_q.status;
	assign O_TCP_GUARD = r_q.tcp_guard;

endmodule
`default_nettype wire

// >>> bench/wd_window_checker.sv
// assertions on the watchdog window ports
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module wd_window_checker (
	input wire logic        I_CLK,
	input wire logic        I_SRST,
	input wire logic        I_REQ_VALID,
	input wire logic        I_REQ_WRITE,
	input wire logic [15:0] I_REQ_ADDR,
	input wire logic [15:0] I_REQ_WDATA,
	input wire logic [7:0]  O_RSP_EXCEPTION,
	input wire logic        O_EXPIRE_EVENT,
	input wire logic [15:0] O_WD_STATUS
);
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST);
	logic        cmd_wr;
	logic        tmo_wr;
	logic [15:0] st;
	logic [15:0] wd;
	assign cmd_wr = I_REQ_VALID && I_REQ_WRITE && I_REQ_ADDR == 16'hfa00;
	assign tmo_wr = I_REQ_VALID && I_REQ_WRITE && I_REQ_ADDR == 16'hfa01;
	assign st = O_WD_STATUS;
	assign wd = I_REQ_WDATA;
	property p_start_ok;
		cmd_wr && wd == 16'h5555 && st == 16'h0000
			|=> O_RSP_EXCEPTION == 8'h00 && st == 16'h0001;
	endproperty
	a_start_ok: assert property (p_start_ok)
		else $error("start from stopped not accepted");
	property p_start_bad;
		cmd_wr && wd == 16'h5555 && (st == 16'hffff || st == 16'h0002)
			|=> O_RSP_EXCEPTION == 8'h03 && $stable(st);
	endproperty
	a_start_bad: assert property (p_start_bad)
		else $error("start not refused");
	property p_stop_bad;
		cmd_wr && wd == 16'h55aa && st == 16'hffff
			|=> O_RSP_EXCEPTION == 8'h03;
	endproperty
	a_stop_bad: assert property (p_stop_bad)
		else $error("stop while unconfigured not refused");
	property p_reset_bad;
		cmd_wr && wd == 16'haaaa && st != 16'h0002
			|=> O_RSP_EXCEPTION == 8'h03;
	endproperty
	a_reset_bad: assert property (p_reset_bad)
		else $error("reset outside expiry not refused");
	property p_bad_cmd;
		cmd_wr && !(wd inside {16'h5555, 16'h55aa, 16'haaaa})
			|=> O_RSP_EXCEPTION == 8'h03 && $stable(st);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("unknown command not refused");
	property p_tmo_locked;
		tmo_wr && (st == 16'h0001 || st == 16'h0002)
			|=> O_RSP_EXCEPTION == 8'h01;
	endproperty
	a_tmo_locked: assert property (p_tmo_locked)
		else $error("timeout write while active not refused");
	property p_expire;
		$rose(O_EXPIRE_EVENT) |-> st == 16'h0002 && $past(st) == 16'h0001;
	endproperty
	a_expire: assert property (p_expire)
		else $error("expiry event without running to expired");
	property p_unconf;
		tmo_wr && wd == 16'h0000 && (st == 16'hffff || st == 16'h0000)
			|=> st == 16'hffff && O_RSP_EXCEPTION == 8'h00;
	endproperty
	a_unconf: assert property (p_unconf)
		else $error("zero timeout does not read unconfigured");
endmodule
bind modbus_comm_watchdog_regs wd_window_checker chk_u (
	.I_CLK(I_CLK), .I_SRST(I_SRST), .I_REQ_VALID(I_REQ_VALID),
	.I_REQ_WRITE(I_REQ_WRITE), .I_REQ_ADDR(I_REQ_ADDR),
	.I_REQ_WDATA(I_REQ_WDATA), .O_RSP_EXCEPTION(O_RSP_EXCEPTION),
	.O_EXPIRE_EVENT(O_EXPIRE_EVENT), .O_WD_STATUS(O_WD_STATUS)
);
`default_nettype wire

// >>> bench/modbus_master_model.sv
// behavioural register master on the far side of the window
// assumes calls start on a falling edge; answers come within 4 cycles
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
	input  wire logic        i_clk,
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_data,
	input  wire logic [7:0]  i_rsp_exc,
	output logic             o_valid,
	output logic             o_write,
	output logic      [15:0] o_addr,
	output logic      [15:0] o_wdata,
	output logic             o_query
);
	int lost = 0;

	initial begin
		o_valid = 1'b0;
		o_write = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
		o_query = 1'b0;
	end

	// one word per request, multi-word functions arrive split
	task automatic xfer(input logic w, input logic [15:0] a, d,
			output logic [15:0] got, output logic [7:0] ex);
		int n;
		o_valid = 1'b1;
		o_write = w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_valid = 1'b0;
		// released lines must not keep their last value
		o_write = ~w;
		o_addr = ~a;
		o_wdata = ~d;
		for (n = 0; n < 4 && i_rsp_valid !== 1'b1; n++)
			@(negedge i_clk);
		got = i_rsp_data;
		ex = i_rsp_exc;
		if (n == 4)
			lost++;
		@(negedge i_clk);
	endtask

	// a valid query served elsewhere by the protocol engine
	task automatic pulse;
		o_query = 1'b1;
		@(negedge i_clk);
		o_query = 1'b0;
		@(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> bench/modbus_comm_watchdog_regs_test.sv
// self-checking bench for the watchdog register window
// assumes a 4-cycle millisecond so that timeouts stay short
`timescale 1ns/1ps
`default_nettype none
module modbus_comm_watchdog_regs_test;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        running = 1'b0;
	logic        valid;
	logic        write;
	logic        query;
	logic        rsp_valid;
	logic        expire;
	logic        close_tcp;
	logic [15:0] tcp_guard;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rsp_data;
	logic [15:0] status;
	logic [7:0]  rsp_exc;
	int          failures = 0;
	int          tests_run = 0;
	// address above, expected word below
	logic [31:0] fixed [19] = '{32'hfa40_7d00, 32'hfa41_7d00, 32'hfa42_8000,
		32'hfa43_7d00, 32'hfa44_7d00, 32'hfa45_8000, 32'hfaa0_1234,
		32'hfaa1_aaaa, 32'hfaa2_5555, 32'hfa0a_0003, 32'hfa0b_0005,
		32'hfa0c_0007, 32'hfa20_0200, 32'hfa21_0000, 32'hfa22_0001,
		32'hfa10_0011, 32'hfa11_0022, 32'hfa12_0033, 32'hfa13_0044};

	always #20 clk = ~clk;

	// order code overridden so that every word of it is distinct
	modbus_comm_watchdog_regs #(
		.TICK_CYCLES(4), .ORDER_CODE(64'h0011_0022_0033_0044)
	) dut_u (
		.I_CLK(clk), .I_SRST(srst), .I_REQ_VALID(valid),
		.I_REQ_WRITE(write), .I_REQ_ADDR(addr), .I_REQ_WDATA(wdata),
		.I_QUERY_SEEN(query), .O_RSP_VALID(rsp_valid),
		.O_RSP_DATA(rsp_data), .O_RSP_EXCEPTION(rsp_exc),
		.I_IO_INDICATOR_CODE(48'h0003_0005_0007),
		.I_CONTROLLER_RUNNING(running), .I_HW_ADDRESS(48'h0200_0000_0001),
		.O_EXPIRE_EVENT(expire), .O_CLOSE_TCP(close_tcp),
		.O_WD_STATUS(status), .O_TCP_GUARD(tcp_guard)
	);

	modbus_master_model master_u (
		.i_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
		.i_rsp_exc(rsp_exc), .o_valid(valid), .o_write(write),
		.o_addr(addr), .o_wdata(wdata), .o_query(query)
	);

	task automatic close_out;
		failures += master_u.lost;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] s, e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic acc(input logic w, input logic [15:0] a, d, e,
			input logic [7:0] x);
		logic [15:0] got;
		logic [7:0]  ex;
		master_u.xfer(w, a, d, got, ex);
		chk($sformatf("exc %h", a), {8'h00, ex}, {8'h00, x});
		chk($sformatf("data %h", a), got, e);
	endtask

	task automatic wr(input logic [15:0] a, d, input logic [7:0] x);
		acc(1'b1, a, d, 16'h0000, x);
	endtask

	task automatic rd(input logic [15:0] a, e);
		acc(1'b0, a, 16'h0000, e, 8'h00);
	endtask

	task automatic st(input logic [15:0] e);
		chk("status", status, e);
	endtask

	task automatic wait_evt(input int lim, input logic cl);
		int n;
		for (n = 0; n < lim && expire !== 1'b1; n++)
			@(negedge clk);
		chk("expire", {15'h0000, expire}, 16'h0001);
		// close request pulses with the event only when option bit 2 is set
		chk("close", {15'h0000, close_tcp}, {15'h0000, cl});
		if (n == lim)
			close_out();
		@(negedge clk);
	endtask

	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		st(16'hffff);
		rd(16'hfa03, 16'h0004);
		wr(16'hfa00, 16'h5555, 8'h03);
		wr(16'hfa00, 16'h55aa, 8'h03);
		wr(16'hfa00, 16'haaaa, 8'h03);
		foreach (fixed[i])
			rd(fixed[i][31:16], fixed[i][15:0]);
		rd(16'hfa0d, 16'h0001);
		running = 1'b1;
		rd(16'hfa0d, 16'h0002);
		acc(1'b0, 16'hfa05, 16'h0000, 16'h0000, 8'h02);
		wr(16'hfa40, 16'h0001, 8'h02);
		wr(16'hfa04, 16'h00c8, 8'h00);
		rd(16'hfa04, 16'h00c8);
		chk("guard", tcp_guard, 16'h00c8);
		wr(16'hfa01, 16'h0000, 8'h00);
		st(16'hffff);
		wr(16'hfa01, 16'h0014, 8'h00);
		st(16'h0000);
		rd(16'hfa01, 16'h0014);
		wr(16'hfa00, 16'h1234, 8'h03);
		st(16'h0000);
		wr(16'hfa00, 16'haaaa, 8'h03);
		wr(16'hfa03, 16'h0005, 8'h00);
		wr(16'hfa00, 16'h5555, 8'h00);
		st(16'h0001);
		wr(16'hfa01, 16'h0005, 8'h01);
		rd(16'hfa01, 16'h0014);
		// explicit mode: only the start word keeps it alive
		repeat (3) begin
			repeat (45) @(negedge clk);
			wr(16'hfa00, 16'h5555, 8'h00);
		end
		st(16'h0001);
		repeat (70) @(negedge clk);
		st(16'h0001);
		master_u.pulse();
		wait_evt(20, 1'b1);
		st(16'h0002);
		wr(16'hfa00, 16'h5555, 8'h03);
		wr(16'hfa01, 16'h0005, 8'h01);
		wr(16'hfa00, 16'haaaa, 8'h00);
		st(16'h0000);
		wr(16'hfa03, 16'h0004, 8'h00);
		wr(16'hfa00, 16'h5555, 8'h00);
		repeat (3) begin
			repeat (45) @(negedge clk);
			master_u.pulse();
		end
		st(16'h0001);
		wr(16'hfa00, 16'h55aa, 8'h00);
		st(16'h0000);
		wr(16'hfa03, 16'h0080, 8'h00);
		wr(16'hfa01, 16'h000a, 8'h00);
		st(16'h0001);
		wr(16'hfa00, 16'h55aa, 8'h03);
		wr(16'hfa00, 16'haaaa, 8'h03);
		wait_evt(60, 1'b0);
		master_u.pulse();
		repeat (2) @(negedge clk);
		st(16'h0001);
		close_out();
	end
endmodule
`default_nettype wire
